/* lcc_core.sv */
module lcc_core #(
	parameter longint unsigned TIMEOUT_CYC = lcc_pkg::LASER_TIMEOUT_CYC,
	parameter int unsigned PULSE_HALF = lcc_pkg::PULSE_HALF_CYC,
	parameter int unsigned BEAMS = lcc_pkg::BEAMS_DEF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic refl_in,
	input wire logic test_active,
	input wire logic [BEAMS-1:0] beam_rx,
	input wire logic selftest_pass,
	input wire logic [1:0] sso_readback,
	output lcc_pkg::lcc_laser_drive_t integrated_alignment_laser,
	output logic [BEAMS-1:0] beam_tx,
	output logic [1:0] safety_switch_output,
	output lcc_pkg::lcc_rx_status_t rx_status,
	output logic fault
);
	import lcc_pkg::*;

	// Refuse counts the fixed-width counters cannot hold
	if (BEAMS < 2 || BEAMS > 64) begin : g_bad_beams
		$error("BEAMS out of range");
	end
	if (PULSE_HALF < 1 || TIMEOUT_CYC < 2 || TIMEOUT_CYC > 40'hff_ffff_ffff) begin : g_bad_time
		$error("timing counts out of range");
	end

	localparam int unsigned BW = $clog2(BEAMS);

	logic toggle_pulse;

	lcc_refl_qual #(
		.QUAL_CYC(REFL_QUAL_CYC)
	) u_qual (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.refl_in(refl_in),
		.toggle_pulse(toggle_pulse)
	);

	// Laser power state, idle timer and blink phase
	lcc_las_t las_q, las_d;
	logic [39:0] idle_q, idle_d;
	logic [31:0] blink_q, blink_d;
	logic phase_q, phase_d;
	lcc_laser_drive_t las_out_q, las_out_d;

	always_comb begin
		las_d = las_q;
		idle_d = idle_q;
		blink_d = blink_q;
		phase_d = phase_q;
		if (toggle_pulse) begin
			las_d = (las_q == LCC_LAS_LOW) ? LCC_LAS_HIGH : LCC_LAS_LOW;
			idle_d = '0;
			blink_d = '0;
			phase_d = 1'b1;
		end else if (las_q == LCC_LAS_HIGH) begin
			if (idle_q == 40'(TIMEOUT_CYC - 1)) begin
				las_d = LCC_LAS_LOW;
				idle_d = '0;
			end else begin
				idle_d = idle_q + 40'h0_0001;
			end
			if (blink_q == 32'(PULSE_HALF - 1)) begin
				blink_d = '0;
				phase_d = ~phase_q;
			end else begin
				blink_d = blink_q + 32'h0000_0001;
			end
		end
		las_out_d.high_power = (las_d == LCC_LAS_HIGH);
		// Low power is steady; high power blinks so the finger shows against glare
		las_out_d.enable = (las_d == LCC_LAS_LOW) || phase_d;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			las_q <= LCC_LAS_LOW;
			idle_q <= '0;
			blink_q <= '0;
			phase_q <= 1'b1;
			las_out_q <= '{enable: 1'b1, high_power: 1'b0};
		end else if (clk_en) begin
			las_q <= las_d;
			idle_q <= idle_d;
			blink_q <= blink_d;
			phase_q <= phase_d;
			las_out_q <= las_out_d;
		end
	end

	assign integrated_alignment_laser = las_out_q;

	// Beam scan: one beam at a time, beam 0 is the sync beam
	logic [BW-1:0] beam_idx_q, beam_idx_d;
	logic [1:0] slot_q, slot_d;
	logic [BEAMS-1:0] tx_q, tx_d;
	logic [BEAMS-1:0] seen_q, seen_d;
	logic sync_q, sync_d;
	logic clear_q, clear_d;

	always_comb begin
		beam_idx_d = beam_idx_q;
		slot_d = slot_q + 2'h1;
		seen_d = seen_q;
		sync_d = sync_q;
		clear_d = clear_q;
		// Sample the receiver mid slot, after the pulse is out
		if (slot_q == 2'h2) begin
			seen_d[beam_idx_q] = beam_rx[beam_idx_q];
			if (beam_idx_q == '0) begin
				sync_d = beam_rx[0];
			end
		end
		if (slot_q == 2'(BEAM_SLOT_CYC - 1)) begin
			if (beam_idx_q == BW'(BEAMS - 1)) begin
				beam_idx_d = '0;
				// One full scan decides; any miss blocks the field
				clear_d = &seen_d && sync_d && !test_active;
			end else begin
				beam_idx_d = beam_idx_q + BW'(1);
			end
		end
		tx_d = '0;
		if (!test_active && slot_d == 2'h1) begin
			tx_d[beam_idx_d] = 1'b1;
		end
		if (test_active) begin
			tx_d = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			beam_idx_q <= '0;
			slot_q <= '0;
			tx_q <= '0;
			seen_q <= '0;
			sync_q <= 1'b0;
			clear_q <= 1'b0;
		end else if (clk_en) begin
			beam_idx_q <= beam_idx_d;
			slot_q <= slot_d;
			tx_q <= tx_d;
			seen_q <= seen_d;
			sync_q <= sync_d;
			clear_q <= clear_d;
		end
	end

	assign beam_tx = tx_q;

	// Sequencer: self-test, wait for clear field, then guard with auto restart
	lcc_state_t st_q, st_d;
	logic [4:0] st_cnt_q, st_cnt_d;
	logic [1:0] xmon_q, xmon_d;
	logic [1:0] sso_q, sso_d;
	logic fault_q, fault_d;
	lcc_rx_status_t status_q, status_d;

	always_comb begin
		st_d = st_q;
		st_cnt_d = st_cnt_q;
		xmon_d = '0;
		fault_d = fault_q;
		sso_d = SSO_OFF;
		unique case (st_q)
			LCC_ST_SELFTEST: begin
				if (st_cnt_q == 5'(SELFTEST_CYC - 1)) begin
					st_d = selftest_pass ? LCC_ST_WAIT_CLEAR : LCC_ST_FAULT;
				end else begin
					st_cnt_d = st_cnt_q + 5'h01;
				end
			end
			LCC_ST_WAIT_CLEAR: begin
				if (clear_q) begin
					st_d = LCC_ST_ON;
				end
			end
			LCC_ST_ON: begin
				// No restart input: clearing the field alone re-enables outputs
				sso_d = clear_q ? SSO_ON : SSO_OFF;
				// Readback must agree with the drive on both channels
				if (sso_readback != sso_q) begin
					xmon_d = xmon_q + 2'h1;
				end
				if (xmon_q == 2'(XMON_CYC - 1) && sso_readback != sso_q) begin
					st_d = LCC_ST_FAULT;
					sso_d = SSO_OFF;
				end
			end
			LCC_ST_FAULT: begin
				fault_d = 1'b1; // Latched until power cycle
			end
		endcase
		status_d.sync_ok = sync_q;
		status_d.field_clear = clear_q;
		status_d.selftest_ok = (st_q == LCC_ST_WAIT_CLEAR) || (st_q == LCC_ST_ON);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_q <= LCC_ST_SELFTEST;
			st_cnt_q <= '0;
			xmon_q <= '0;
			sso_q <= SSO_OFF;
			fault_q <= 1'b0;
			status_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
			st_cnt_q <= st_cnt_d;
			xmon_q <= xmon_d;
			sso_q <= sso_d;
			fault_q <= fault_d;
			status_q <= status_d;
		end
	end

	assign safety_switch_output = sso_q;
	assign rx_status = status_q;
	assign fault = fault_q;

	toggle_flips_a: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && toggle_pulse |=> las_q != $past(las_q))
		else $error("laser state did not toggle on qualified finger");
	timeout_low_a: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && las_q == LCC_LAS_HIGH && idle_q == 40'(TIMEOUT_CYC - 1) && !toggle_pulse
		|=> las_q == LCC_LAS_LOW)
		else $error("high power did not time out");
	low_steady_a: assert property (@(posedge sys_clk) disable iff (rst)
		las_q == LCC_LAS_LOW && !$past(toggle_pulse) |=> integrated_alignment_laser.enable)
		else $error("low power laser not steady");
	blocked_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && !clear_q |=> safety_switch_output == SSO_OFF)
		else $error("outputs on with blocked field");
	selftest_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		st_q == LCC_ST_SELFTEST |-> safety_switch_output == SSO_OFF)
		else $error("outputs on before self-test");
	test_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && test_active |=> beam_tx == '0)
		else $error("beam emitted during test input");
	auto_restart_a: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && st_q == LCC_ST_ON && clear_q && sso_readback == sso_q
		|=> safety_switch_output == SSO_ON)
		else $error("outputs did not restart on clear field");
	pair_equal_a: assert property (@(posedge sys_clk) disable iff (rst)
		safety_switch_output[0] == safety_switch_output[1])
		else $error("safety channels disagree");
	one_beam_a: assert property (@(posedge sys_clk) disable iff (rst)
		$onehot0(beam_tx))
		else $error("more than one beam lit");
endmodule : lcc_core

/* lcc_pkg.sv */
package lcc_pkg;
	// Timing figures in their own units, cycle counts derived from the 250 MHz clock
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned LASER_TIMEOUT_S = 5 * 60;
	localparam longint unsigned LASER_TIMEOUT_CYC = longint'(LASER_TIMEOUT_S) * CLK_HZ;
	localparam int unsigned PULSE_HZ = 2;
	localparam int unsigned PULSE_HALF_CYC = CLK_HZ / (2 * PULSE_HZ);
	localparam int unsigned REFL_QUAL_CYC = 8;
	localparam int unsigned SELFTEST_CYC = 16;
	localparam int unsigned BEAMS_DEF = 8;
	localparam int unsigned BEAM_SLOT_CYC = 4;
	localparam int unsigned XMON_CYC = 3;
	localparam logic [1:0] SSO_OFF = 2'h0;
	localparam logic [1:0] SSO_ON = 2'h3;

	// Main sequencer states
	typedef enum logic [1:0] {
		LCC_ST_SELFTEST,
		LCC_ST_WAIT_CLEAR,
		LCC_ST_ON,
		LCC_ST_FAULT
	} lcc_state_t;

	// Laser power states
	typedef enum logic {
		LCC_LAS_LOW,
		LCC_LAS_HIGH
	} lcc_las_t;

	// Receiver status carried together
	typedef struct packed {
		logic sync_ok;
		logic field_clear;
		logic selftest_ok;
	} lcc_rx_status_t;

	// Laser drive carried together
	typedef struct packed {
		logic enable;
		logic high_power;
	} lcc_laser_drive_t;
endpackage : lcc_pkg

/* lcc_refl_qual.sv */
// Reflection detector qualifier: emits one pulse per settled rising level
module lcc_refl_qual #(
	parameter int unsigned QUAL_CYC = lcc_pkg::REFL_QUAL_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic refl_in,
	output logic toggle_pulse
);
	import lcc_pkg::*;

	localparam int unsigned CW = $clog2(QUAL_CYC + 1);

	// A one-cycle window could not tell a touch from glare
	if (QUAL_CYC < 2) begin : g_bad_qual
		$error("QUAL_CYC must be at least 2");
	end

	logic [CW-1:0] cnt_q, cnt_d;
	logic level_q, level_d;
	logic pulse_q, pulse_d;

	// Level must hold for QUAL_CYC before it is accepted; glare spikes are ignored
	always_comb begin
		cnt_d = cnt_q;
		level_d = level_q;
		pulse_d = 1'b0;
		if (refl_in == level_q) begin
			cnt_d = '0;
		end else if (cnt_q == CW'(QUAL_CYC - 1)) begin
			cnt_d = '0;
			level_d = refl_in;
			pulse_d = refl_in;
		end else begin
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_q <= '0;
			level_q <= 1'b0;
			pulse_q <= 1'b0;
		end else if (clk_en) begin
			cnt_q <= cnt_d;
			level_q <= level_d;
			pulse_q <= pulse_d;
		end
	end

	assign toggle_pulse = pulse_q;

	one_toggle_a: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && toggle_pulse |=> !toggle_pulse)
		else $error("reflection qualifier pulsed twice in a row");
endmodule : lcc_refl_qual

/* lcc_stop_model.sv */
// Machine stop circuit: relays echo the safety outputs back
module lcc_stop_model (
	input wire logic [1:0] safety_switch_output,
	input wire logic test_req,
	input wire logic break_rb,
	output logic [1:0] sso_readback,
	output logic test_active
);
	timeunit 1ns;
	timeprecision 1ns;
	// A welded contact flips one readback, the only wrong answer we give
	always_comb begin
		sso_readback = safety_switch_output ^ {1'b0, break_rb};
	end
	// Jumper holds the input enabling until the controller runs a test
	always_comb begin
		test_active = test_req;
	end
endmodule : lcc_stop_model

/* lcc_core_bench.sv */
module lcc_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import lcc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic refl_in = 1'b0;
	logic test_req = 1'b0;
	logic break_rb = 1'b0;
	logic clk_en = 1'b1;
	logic selftest_pass = 1'b0;
	logic [7:0] block = 8'h00;
	logic [7:0] lit_q = 8'h00;
	logic [7:0] beam_rx;
	logic [7:0] beam_tx;
	logic test_active;
	logic [1:0] sso_readback;
	logic [1:0] sso;
	lcc_laser_drive_t las;
	lcc_rx_status_t rx_status;
	logic fault;
	logic e0;
	int bad_count = 0;
	int num_checks = 0;
	// 250 MHz
	always #2 sys_clk = ~sys_clk;
	// Receiver echo lasts one cycle past the pulse; a dark transmitter is seen dark
	always_ff @(posedge sys_clk) begin
		lit_q <= beam_tx & ~block;
	end
	assign beam_rx = lit_q | (beam_tx & ~block);
	// Short timers keep the run brief
	lcc_core #(.TIMEOUT_CYC(200), .PULSE_HALF(10), .BEAMS(8)) lcc_core_i (
		.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .refl_in(refl_in),
		.test_active(test_active), .beam_rx(beam_rx), .selftest_pass(selftest_pass),
		.sso_readback(sso_readback), .integrated_alignment_laser(las),
		.beam_tx(beam_tx), .safety_switch_output(sso), .rx_status(rx_status),
		.fault(fault));
	lcc_stop_model lcc_stop_model_i (.safety_switch_output(sso), .test_req(test_req),
		.break_rb(break_rb), .sso_readback(sso_readback), .test_active(test_active));
	task chk1(input string what, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %b got %b", what, e, g);
		end
	endtask : chk1
	task chk8(input string what, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", what, e, g);
		end
	endtask : chk8
	task final_report;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	// Sample at the falling edge, where registered outputs are settled
	task run(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : run
	task do_reset(input logic pass);
		@(posedge sys_clk);
		rst <= 1'b1;
		selftest_pass <= pass;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
	endtask : do_reset
	task wait_sso(input logic [1:0] e, input int lim);
		for (int i = 0; i < lim && sso !== e; i++) @(negedge sys_clk);
		chk8("safety outputs", 8'(e), 8'(sso));
	endtask : wait_sso
	task finger(input int n);
		@(posedge sys_clk);
		refl_in <= 1'b1;
		repeat (n) @(posedge sys_clk);
		refl_in <= 1'b0;
		repeat (10) @(posedge sys_clk);
		run(1);
	endtask : finger
	// Failed self-test keeps outputs off; a passing one reaches on-state
	task t_selftest;
		do_reset(1'b0);
		run(200);
		chk8("outputs after failed test", 8'h00, 8'(sso));
		do_reset(1'b1);
		run(1);
		chk1("laser high at reset", 1'b0, las.high_power);
		wait_sso(SSO_ON, 200);
		chk1("selftest ok", 1'b1, rx_status.selftest_ok);
	endtask : t_selftest
	// Sync beam leads, next beam one slot later
	task t_scan;
		for (int i = 0; i < 100 && beam_tx !== 8'h01; i++) @(negedge sys_clk);
		chk8("sync beam", 8'h01, beam_tx);
		run(4);
		chk8("second beam", 8'h02, beam_tx);
	endtask : t_scan
	// First and last beam blocked; restart comes with no command
	task t_block;
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			block <= (k == 0) ? 8'h01 : 8'h80;
			wait_sso(SSO_OFF, 100);
			chk1("field clear", 1'b0, rx_status.field_clear);
			chk1("sync ok", (k == 1), rx_status.sync_ok);
			@(posedge sys_clk);
			block <= 8'h00;
			wait_sso(SSO_ON, 100);
		end
	endtask : t_block
	// External test silences the transmitter
	task t_test;
		logic [7:0] seen;
		seen = 8'h00;
		@(posedge sys_clk);
		test_req <= 1'b1;
		run(2);
		for (int i = 0; i < 40; i++) begin
			run(1);
			seen = seen | beam_tx;
		end
		chk8("emission under test", 8'h00, seen);
		wait_sso(SSO_OFF, 100);
		@(posedge sys_clk);
		test_req <= 1'b0;
		wait_sso(SSO_ON, 150);
	endtask : t_test
	// Short touch ignored, long hold toggles once, idle falls back
	task t_laser;
		finger(4);
		chk1("short touch", 1'b0, las.high_power);
		finger(12);
		chk1("to high", 1'b1, las.high_power);
		e0 = las.enable;
		run(10);
		chk1("blink", ~e0, las.enable);
		// Enable low must freeze the blink, else one half period would flip it
		@(posedge sys_clk);
		clk_en <= 1'b0;
		run(2);
		e0 = las.enable;
		run(10);
		chk1("frozen blink", e0, las.enable);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		finger(20);
		chk1("back low", 1'b0, las.high_power);
		finger(12);
		run(150);
		chk1("before idle", 1'b1, las.high_power);
		run(70);
		chk1("after idle", 1'b0, las.high_power);
	endtask : t_laser
	// Readback disagreement latches a fault with outputs off
	task t_fault;
		@(posedge sys_clk);
		break_rb <= 1'b1;
		run(10);
		chk1("fault", 1'b1, fault);
		chk8("outputs on fault", 8'h00, 8'(sso));
		@(posedge sys_clk);
		break_rb <= 1'b0;
		run(50);
		chk1("fault latched", 1'b1, fault);
	endtask : t_fault
	initial begin
		t_selftest();
		t_scan();
		t_block();
		t_test();
		t_laser();
		t_fault();
		final_report();
	end
	// Whole run needs about 1000 cycles
	initial begin
		#40000;
		bad_count++;
		final_report();
	end
endmodule : lcc_core_bench
